/* shared/pscs_pkg.sv */
////////////////////////////////////////////////////////////////////////
// shared constants for the synthesizer configuration sequencer
package pscs_pkg;

	// programming word layout
	localparam int WORD_W = 32;
	localparam int SEL_W = 4;
	localparam int REG_LAST = 12;
	localparam logic [SEL_W-1:0] SEL_R0 = 4'h0;
	localparam logic [SEL_W-1:0] SEL_R4 = 4'h4;
	localparam logic [SEL_W-1:0] SEL_R8 = 4'h8;
	localparam logic [SEL_W-1:0] SEL_R9 = 4'h9;
	localparam logic [SEL_W-1:0] SEL_R10 = 4'ha;
	localparam logic [SEL_W-1:0] SEL_R11 = 4'hb;
	localparam logic [SEL_W-1:0] SEL_R12 = 4'hc;
	localparam logic [WORD_W-1:0] REG_RESET = 32'h00000000;

	// frequency words: register 0, 1, 2, 6
	localparam int INT_LSB = 4;
	localparam int INT_W = 16;
	localparam int AUTOCAL_BIT = 21;
	localparam int FRACTION_WORD_LSB = 4;
	localparam int FRACTION_WORD_W = 24;
	localparam int AUX_FRACTION_LSB = 18;
	localparam int AUX_FRACTION_W = 14;
	localparam int AUX_MODULUS_LSB = 4;
	localparam int AUX_MODULUS_W = 14;
	localparam int RFDIV_LSB = 21;
	localparam int RFDIV_W = 3;

	// reference path: register 4
	localparam int CRST_BIT = 4;
	localparam int RCNT_LSB = 15;
	localparam int RCNT_W = 10;
	localparam int HALVE_BIT = 25;
	localparam int DBL_BIT = 26;
	localparam logic [RCNT_W:0] REF_DIV_ONE = 11'h001;

	// lock detect: register 7
	localparam int LDP_LSB = 5;
	localparam int LDM_BIT = 4;
	localparam logic [15:0] WIN_5P0_PS = 16'h1388;
	localparam logic [15:0] WIN_6P0_PS = 16'h1770;
	localparam logic [15:0] WIN_8P0_PS = 16'h1f40;
	localparam logic [15:0] WIN_12P0_PS = 16'h2ee0;
	localparam logic [15:0] WIN_2P9_PS = 16'h0b54;

	// calibration timing: register 9
	localparam int BAND_LSB = 24;
	localparam int TMO_LSB = 14;
	localparam int ALC_LSB = 9;
	localparam int SETTLE_LSB = 4;
	localparam int CAL_W = 22;
	localparam logic [CAL_W-1:0] BAND_CYCLES = 22'h00000b;
	localparam logic [CAL_W-1:0] LEVEL_REPEAT = 22'h000037;

	// converter and resync: registers 10, 12
	localparam int CDIV_LSB = 6;
	localparam int CONV_WR_BIT = 5;
	localparam int CONV_PWR_BIT = 4;
	localparam int RESYNC_LSB = 16;

	// fixed and reserved contents
	localparam logic [WORD_W-1:0] FIXED_R8 = 32'h102d0428;
	localparam logic [WORD_W-1:0] FIXED_R11 = 32'h0061300b;
	localparam logic [WORD_W-1:0] R10_RSVD_MASK = 32'hffffc000;
	localparam logic [WORD_W-1:0] R10_RSVD_VAL = 32'h00c00000;
	localparam logic [WORD_W-1:0] R12_RSVD_MASK = 32'h0000fff0;
	localparam logic [WORD_W-1:0] R12_RSVD_VAL = 32'h00000410;

	typedef enum logic [1:0] {CAL_IDLE, CAL_SETTLE, CAL_BAND, CAL_LEVEL} pscs_cal_t;

endpackage : pscs_pkg

/* src/pscs_serial_rx.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// three-wire word receiver, msb first, latched on load enable rise
module pscs_serial_rx
	import pscs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic ser_le,
	output logic word_valid,
	output logic [WORD_W-1:0] word
);

	logic sclk_q_r;
	logic le_q_r;
	logic [WORD_W-1:0] shift_r;

	// edge history of the serial pins
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sclk_q_r <= 1'b0;
			le_q_r <= 1'b0;
		end
		else
		begin
			sclk_q_r <= ser_clk;
			le_q_r <= ser_le;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			shift_r <= '0;
		else if (ser_clk && !sclk_q_r)
			shift_r <= {shift_r[WORD_W-2:0], ser_data};
	end

	// hand the last 32 bits over on load enable rise
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			word_valid <= 1'b0;
			word <= '0;
		end
		else
		begin
			word_valid <= ser_le && !le_q_r;
			if (ser_le && !le_q_r)
				word <= shift_r;
		end
	end

endmodule : pscs_serial_rx

/* src/pscs_tick_div.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// divides a stream of one-cycle ticks; divisor zero acts as one
module pscs_tick_div #(
	parameter int DIV_W = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clr,
	input wire logic tick_in,
	input wire logic [DIV_W-1:0] divisor,
	output logic tick_out
);

	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W:0] cnt_inc;

	assign cnt_inc = {1'b0, cnt_r} + 1'b1;

	// count input ticks, emit one tick per divisor inputs
	always_ff @(posedge clk)
	begin
		if (!rst_b || clr)
		begin
			cnt_r <= '0;
			tick_out <= 1'b0;
		end
		else
		begin
			tick_out <= 1'b0;
			if (tick_in)
			begin
				if (cnt_inc >= {1'b0, divisor})
				begin
					cnt_r <= '0;
					tick_out <= 1'b1;
				end
				else
					cnt_r <= cnt_inc[DIV_W-1:0];
			end
		end
	end

endmodule : pscs_tick_div

/* src/pscs_top.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Overview of operation
// - precision field picks 5/6/8/12 ns window
// - mode bit forces fixed 2.9 ns window
// - select code routes word to its register
// - band clock is detector rate over sixteen-times field
// - timeout field scales the settle and level waits
// - LEVEL_REPEAT times level wait times timeout sets level timer
// - settle field times timeout sets settle time
// - converter clock is detector tick over divisor
// - write starts conversion; power bit enables converter
// - resync fires after counted detector cycles
// - frequency changes only on register zero write
// - output uses whole, fraction, aux fraction, aux modulus, divider
// - detector rate from reference, doubler, counter, halving
// - counter reset holds counters and band select
module pscs_top
	import pscs_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_B,
	input wire logic SER_CLK,
	input wire logic SER_DATA,
	input wire logic SER_LE,
	input wire logic REF_TICK,
	output logic PFD_TICK,
	output logic REF_DOUBLE,
	output logic CONV_TICK,
	output logic CONV_START,
	output logic CONV_POWER,
	output logic [15:0] LOCK_WINDOW_PS,
	output logic CAL_BUSY,
	output logic RESYNC,
	output logic FREQ_UPDATE,
	output logic [INT_W-1:0] INT_APPLIED,
	output logic [FRACTION_WORD_W-1:0] FRACTION_WORD_APPLIED,
	output logic [AUX_FRACTION_W-1:0] AUX_FRACTION_APPLIED,
	output logic [AUX_MODULUS_W-1:0] AUX_MODULUS_APPLIED,
	output logic [RFDIV_W-1:0] RFDIV_APPLIED,
	output logic RSVD_MISMATCH
);

	logic [WORD_W-1:0] regs_r [0:REG_LAST];
	logic wr_valid;
	logic [WORD_W-1:0] wr_word;
	logic [SEL_W-1:0] wr_sel;
	logic wr0;
	logic ref_prog_r;
	logic [RCNT_W:0] ref_divisor;
	logic band_tick;
	pscs_cal_t cal_state_r;
	logic [CAL_W-1:0] cal_cnt_r;
	logic [CAL_W-1:0] cal_inc;
	logic [CAL_W-1:0] settle_target;
	logic [CAL_W-1:0] level_target;
	logic [15:0] resync_cnt_r;
	logic resync_arm_r;
	logic [3:0] rsvd_bad_r;

	// named fields of the stored registers
	logic [1:0] lock_window_precision;
	logic lock_cycle_mode;
	logic [7:0] band_clock_divisor;
	logic [9:0] calibration_timeout;
	logic [4:0] level_cal_wait;
	logic [4:0] tune_settle_timeout;
	logic [7:0] conv_clock_divisor;
	logic conversion_on_write;
	logic converter_power;
	logic [15:0] resync_counter;
	logic counter_reset;
	logic [RCNT_W-1:0] ref_count;
	logic ref_halve;

	// product of two calibration factors, cut to the counter width
	function automatic logic [CAL_W-1:0] pscs_mul(input logic [CAL_W-1:0] a, input logic [CAL_W-1:0] b);
		logic [2*CAL_W-1:0] p;
		p = a * b;
		return p[CAL_W-1:0];
	endfunction : pscs_mul

	// reserved content check for the fixed and partly fixed words
	function automatic logic pscs_rsvd_bad(input logic [SEL_W-1:0] sel, input logic [WORD_W-1:0] w);
		logic bad;
		bad = 1'b0;
		if (sel == SEL_R8)
			bad = (w != FIXED_R8);
		else if (sel == SEL_R11)
			bad = (w != FIXED_R11);
		else if (sel == SEL_R10)
			bad = ((w & R10_RSVD_MASK) != R10_RSVD_VAL);
		else if (sel == SEL_R12)
			bad = ((w & R12_RSVD_MASK) != R12_RSVD_VAL);
		return bad;
	endfunction : pscs_rsvd_bad

	////////////////////////////////////////////////////////////////////////
	// serial word intake

	pscs_serial_rx u_rx (
		.clk(CLK),
		.rst_b(RST_B),
		.ser_clk(SER_CLK),
		.ser_data(SER_DATA),
		.ser_le(SER_LE),
		.word_valid(wr_valid),
		.word(wr_word)
	);

	assign wr_sel = wr_word[SEL_W-1:0];
	assign wr0 = wr_valid && (wr_sel == SEL_R0);

	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			for (int i = 0; i <= REG_LAST; i++)
				regs_r[i] <= REG_RESET;
		end
		else if (wr_valid && (wr_sel <= SEL_R12))
			regs_r[wr_sel] <= wr_word;
	end

	// field views
	assign lock_window_precision = regs_r[7][LDP_LSB +: 2];
	assign lock_cycle_mode = regs_r[7][LDM_BIT];
	assign band_clock_divisor = regs_r[9][BAND_LSB +: 8];
	assign calibration_timeout = regs_r[9][TMO_LSB +: 10];
	assign level_cal_wait = regs_r[9][ALC_LSB +: 5];
	assign tune_settle_timeout = regs_r[9][SETTLE_LSB +: 5];
	assign conv_clock_divisor = regs_r[10][CDIV_LSB +: 8];
	assign conversion_on_write = regs_r[10][CONV_WR_BIT];
	assign converter_power = regs_r[10][CONV_PWR_BIT];
	assign resync_counter = regs_r[12][RESYNC_LSB +: 16];
	assign counter_reset = regs_r[4][CRST_BIT];
	assign ref_count = regs_r[4][RCNT_LSB +: RCNT_W];
	assign ref_halve = regs_r[4][HALVE_BIT];

	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			rsvd_bad_r <= 4'h0;
			RSVD_MISMATCH <= 1'b0;
		end
		else
		begin
			if (wr_valid && (wr_sel == SEL_R8))
				rsvd_bad_r[0] <= pscs_rsvd_bad(wr_sel, wr_word);
			if (wr_valid && (wr_sel == SEL_R10))
				rsvd_bad_r[1] <= pscs_rsvd_bad(wr_sel, wr_word);
			if (wr_valid && (wr_sel == SEL_R11))
				rsvd_bad_r[2] <= pscs_rsvd_bad(wr_sel, wr_word);
			if (wr_valid && (wr_sel == SEL_R12))
				rsvd_bad_r[3] <= pscs_rsvd_bad(wr_sel, wr_word);
			RSVD_MISMATCH <= |rsvd_bad_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reference counter and detector tick

	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			ref_prog_r <= 1'b0;
		else if (wr_valid && (wr_sel == SEL_R4))
			ref_prog_r <= 1'b1;
	end

	assign ref_divisor = !ref_prog_r ? REF_DIV_ONE : (ref_halve ? {ref_count, 1'b0} : {1'b0, ref_count});

	pscs_tick_div #(.DIV_W(RCNT_W + 1)) u_ref_div (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(counter_reset),
		.tick_in(REF_TICK),
		.divisor(ref_divisor),
		.tick_out(PFD_TICK)
	);

	// doubler is applied ahead of the reference tick
	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			REF_DOUBLE <= 1'b0;
		else
			REF_DOUBLE <= regs_r[4][DBL_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// temperature converter

	pscs_tick_div #(.DIV_W(8)) u_conv_div (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(!converter_power),
		.tick_in(PFD_TICK),
		.divisor(conv_clock_divisor),
		.tick_out(CONV_TICK)
	);

	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			CONV_START <= 1'b0;
			CONV_POWER <= 1'b0;
		end
		else
		begin
			CONV_START <= wr_valid && (wr_sel == SEL_R10) && wr_word[CONV_WR_BIT] && wr_word[CONV_PWR_BIT];
			CONV_POWER <= converter_power;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// lock detect window

	always_ff @(posedge CLK)
	begin
		if (!RST_B)
			LOCK_WINDOW_PS <= WIN_5P0_PS;
		else if (lock_cycle_mode)
			LOCK_WINDOW_PS <= WIN_2P9_PS;
		else
		begin
			unique case (lock_window_precision)
				2'h0: LOCK_WINDOW_PS <= WIN_5P0_PS;
				2'h1: LOCK_WINDOW_PS <= WIN_6P0_PS;
				2'h2: LOCK_WINDOW_PS <= WIN_8P0_PS;
				2'h3: LOCK_WINDOW_PS <= WIN_12P0_PS;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// calibration sequence on detector ticks

	assign settle_target = pscs_mul(CAL_W'(calibration_timeout), CAL_W'(tune_settle_timeout));
	assign level_target = pscs_mul(pscs_mul(LEVEL_REPEAT, CAL_W'(level_cal_wait)), CAL_W'(calibration_timeout));
	assign cal_inc = cal_cnt_r + 1'b1;

	pscs_tick_div #(.DIV_W(12)) u_band_div (
		.clk(CLK),
		.rst_b(RST_B),
		.clr(counter_reset || (cal_state_r != CAL_BAND)),
		.tick_in(PFD_TICK),
		.divisor({band_clock_divisor, 4'h0}),
		.tick_out(band_tick)
	);

	always_ff @(posedge CLK)
	begin
		if (!RST_B || counter_reset)
		begin
			cal_state_r <= CAL_IDLE;
			cal_cnt_r <= '0;
		end
		else if (wr0 && wr_word[AUTOCAL_BIT])
		begin
			cal_state_r <= CAL_SETTLE;
			cal_cnt_r <= '0;
		end
		else
		begin
			unique case (cal_state_r)
				CAL_IDLE: cal_cnt_r <= '0;
				CAL_SETTLE:
					if (PFD_TICK)
					begin
						cal_cnt_r <= (cal_inc >= settle_target) ? '0 : cal_inc;
						if (cal_inc >= settle_target)
							cal_state_r <= CAL_BAND;
					end
				CAL_BAND:
					if (band_tick)
					begin
						cal_cnt_r <= (cal_inc >= BAND_CYCLES) ? '0 : cal_inc;
						if (cal_inc >= BAND_CYCLES)
							cal_state_r <= CAL_LEVEL;
					end
				CAL_LEVEL:
					if (PFD_TICK)
					begin
						cal_cnt_r <= (cal_inc >= level_target) ? '0 : cal_inc;
						if (cal_inc >= level_target)
							cal_state_r <= CAL_IDLE;
					end
			endcase
		end
	end

	assign CAL_BUSY = (cal_state_r != CAL_IDLE);

	////////////////////////////////////////////////////////////////////////
	// frequency apply and phase resync

	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			FREQ_UPDATE <= 1'b0;
			INT_APPLIED <= '0;
			FRACTION_WORD_APPLIED <= '0;
			AUX_FRACTION_APPLIED <= '0;
			AUX_MODULUS_APPLIED <= '0;
			RFDIV_APPLIED <= '0;
		end
		else
		begin
			FREQ_UPDATE <= wr0;
			if (wr0)
			begin
				INT_APPLIED <= wr_word[INT_LSB +: INT_W];
				FRACTION_WORD_APPLIED <= regs_r[1][FRACTION_WORD_LSB +: FRACTION_WORD_W];
				AUX_FRACTION_APPLIED <= regs_r[2][AUX_FRACTION_LSB +: AUX_FRACTION_W];
				AUX_MODULUS_APPLIED <= regs_r[2][AUX_MODULUS_LSB +: AUX_MODULUS_W];
				RFDIV_APPLIED <= regs_r[6][RFDIV_LSB +: RFDIV_W];
			end
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_B)
		begin
			resync_arm_r <= 1'b0;
			resync_cnt_r <= '0;
			RESYNC <= 1'b0;
		end
		else
		begin
			RESYNC <= 1'b0;
			if (wr0)
			begin
				resync_cnt_r <= resync_counter;
				resync_arm_r <= (resync_counter != 16'h0000);
			end
			else if (resync_arm_r && PFD_TICK)
			begin
				if (resync_cnt_r == 16'h0001)
				begin
					resync_arm_r <= 1'b0;
					RESYNC <= 1'b1;
				end
				else
					resync_cnt_r <= resync_cnt_r - 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	sequence s_settle_done;
		(cal_state_r == CAL_SETTLE) && PFD_TICK && (cal_inc >= settle_target) && !wr0 && !counter_reset;
	endsequence

	sequence s_band_done;
		(cal_state_r == CAL_BAND) && band_tick && (cal_inc == BAND_CYCLES) && !wr0 && !counter_reset;
	endsequence

	chk_lock_int_window: assert property (lock_cycle_mode |=> LOCK_WINDOW_PS == WIN_2P9_PS)
		else $error("integer mode window not 2.9 ns");
	chk_lock_frac_window: assert property (!lock_cycle_mode && lock_window_precision == 2'h3
		|=> LOCK_WINDOW_PS == WIN_12P0_PS)
		else $error("precision 3 window not 12 ns");
	chk_decode_cal_reg: assert property (wr_valid && wr_sel == SEL_R9 |=> regs_r[9] == $past(wr_word))
		else $error("code 1001 word not stored");
	chk_freq_hold: assert property (!wr0 |=> $stable(INT_APPLIED) && $stable(FRACTION_WORD_APPLIED))
		else $error("frequency changed without register zero");
	chk_freq_apply: assert property (wr0 |=> FREQ_UPDATE && INT_APPLIED == $past(wr_word[INT_LSB +: INT_W]))
		else $error("register zero not applied");
	chk_conv_start: assert property (wr_valid && wr_sel == SEL_R10 && wr_word[CONV_WR_BIT] && wr_word[CONV_PWR_BIT]
		|=> CONV_START ##1 !CONV_START)
		else $error("converter start not a single pulse");
	chk_crst_hold: assert property (counter_reset |=> !CAL_BUSY && !PFD_TICK)
		else $error("counter reset did not hold calibration");
	chk_ref_div_one: assert property (!ref_prog_r |-> ref_divisor == REF_DIV_ONE)
		else $error("unprogrammed reference counter not one");
	chk_settle_to_band: assert property (s_settle_done |=> cal_state_r == CAL_BAND)
		else $error("settle phase did not advance");
	chk_band_to_level: assert property (s_band_done |=> cal_state_r == CAL_LEVEL)
		else $error("band phase not eleven band ticks");
	chk_resync_fire: assert property (resync_arm_r && PFD_TICK && resync_cnt_r == 16'h0001 && !wr0
		|=> RESYNC ##1 !RESYNC)
		else $error("resync pulse missing");

endmodule : pscs_top

/* bench/pscs_host_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// host side of the three-wire link: shifts words, pulses load enable
module pscs_host_model
	import pscs_pkg::*;
(
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic ser_le
);
	// link idles with clock and load enable low
	initial
	begin
		ser_clk = 1'h0;
		ser_data = 1'h0;
		ser_le = 1'h0;
	end

	// whole word msb first, select code last
	task automatic send_word(input logic [WORD_W-1:0] w);
		for (int i = WORD_W - 1; i >= 0; i--)
		begin
			@(posedge clk) #1;
			ser_data = w[i];
			ser_clk = 1'h1;
			@(posedge clk) #1;
			ser_clk = 1'h0;
		end
		@(posedge clk) #1;
		ser_le = 1'h1;
		@(posedge clk) #1;
		ser_le = 1'h0;
		ser_data = ~w[0]; // no stale bit after the frame
	endtask : send_word
endmodule : pscs_host_model

/* bench/tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// bench: host words in, configuration outputs checked
module tb
	import pscs_pkg::*;
;
	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic ref_tick = 1'h0;
	logic ser_clk, ser_data, ser_le;
	logic pfd_tick, ref_double, conv_tick, conv_start, conv_power;
	logic cal_busy, resync, freq_update, rsvd_mismatch;
	logic [15:0] lock_window_ps;
	logic [INT_W-1:0] int_applied;
	logic [FRACTION_WORD_W-1:0] fraction_word_applied;
	logic [AUX_FRACTION_W-1:0] aux_fraction_applied;
	logic [AUX_MODULUS_W-1:0] aux_modulus_applied;
	logic [RFDIV_W-1:0] rfdiv_applied;
	logic [15:0] wins [4] = '{WIN_5P0_PS, WIN_6P0_PS, WIN_8P0_PS, WIN_12P0_PS};
	int fails = 0;
	int total_checks = 0;
	int n_cyc = 0, n_ref = 0, n_pfd = 0, n_start = 0, n_upd = 0, n_cal = 0, pfd_upd = 0, pfd_rs = 0;

	////////////////////////////////////////////////////////////////
	// clock and a reference tick every other cycle
	always #20 clk = ~clk;
	always @(posedge clk) #1 ref_tick = ~ref_tick;

	pscs_host_model i_pscs_host_model (
		.clk(clk),
		.ser_clk(ser_clk),
		.ser_data(ser_data),
		.ser_le(ser_le)
	);

	pscs_top i_pscs_top (
		.CLK(clk),
		.RST_B(rst_b),
		.SER_CLK(ser_clk),
		.SER_DATA(ser_data),
		.SER_LE(ser_le),
		.REF_TICK(ref_tick),
		.PFD_TICK(pfd_tick),
		.REF_DOUBLE(ref_double),
		.CONV_TICK(conv_tick),
		.CONV_START(conv_start),
		.CONV_POWER(conv_power),
		.LOCK_WINDOW_PS(lock_window_ps),
		.CAL_BUSY(cal_busy),
		.RESYNC(resync),
		.FREQ_UPDATE(freq_update),
		.INT_APPLIED(int_applied),
		.FRACTION_WORD_APPLIED(fraction_word_applied),
		.AUX_FRACTION_APPLIED(aux_fraction_applied),
		.AUX_MODULUS_APPLIED(aux_modulus_applied),
		.RFDIV_APPLIED(rfdiv_applied),
		.RSVD_MISMATCH(rsvd_mismatch)
	);

	////////////////////////////////////////////////////////////////
	// event counters and run ceiling
	always @(posedge clk)
	begin
		n_cyc <= n_cyc + 1;
		if (ref_tick) n_ref <= n_ref + 1;
		if (pfd_tick === 1'h1) n_pfd <= n_pfd + 1;
		if (conv_start === 1'h1) n_start <= n_start + 1;
		if (freq_update === 1'h1) n_upd <= n_upd + 1;
		if (freq_update === 1'h1) pfd_upd <= n_pfd;
		if (resync === 1'h1) pfd_rs <= n_pfd;
		if (cal_busy === 1'h1 && pfd_tick === 1'h1) n_cal <= n_cal + 1;
		if (n_cyc == 40000)
		begin
			fails++;
			stop_test();
		end
	end

	// detector division from the reference word
	function automatic int ref_div(input logic [WORD_W-1:0] r4);
		int r;
		r = (r4[RCNT_LSB +: RCNT_W] == 0) ? 1 : int'(r4[RCNT_LSB +: RCNT_W]);
		return r4[HALVE_BIT] ? 2 * r : r;
	endfunction : ref_div

	// converter divisor, rounded up and clamped
	function automatic logic [7:0] conv_div(input int f);
		int v;
		v = int'($ceil((f / 100000.0 - 2.0) / 4.0));
		return (v > 255) ? 8'hff : v[7:0];
	endfunction : conv_div

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	// verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test

	// one word, then let its effects settle
	task automatic wr(input logic [WORD_W-1:0] w);
		i_pscs_host_model.send_word(w);
		repeat (4) @(posedge clk);
		#2;
	endtask : wr

	// next detector or converter tick; returns reference or detector count
	task automatic wait_on(input int conv, output int r);
		int k;
		k = 0;
		@(posedge clk);
		while (((conv != 0) ? conv_tick : pfd_tick) !== 1'h1 && k < 3000)
		begin
			@(posedge clk);
			k++;
		end
		#2;
		r = (conv != 0) ? n_pfd : n_ref;
	endtask : wait_on

	// spacing between two ticks
	task automatic gap(input int conv, output int g);
		int a, b;
		wait_on(conv, a);
		wait_on(conv, b);
		g = b - a;
	endtask : gap

	////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		logic [WORD_W-1:0] w, m, w0, w1, w2, w6, r4, r9, r10, r12;
		int g, n, u, s, e, bi;
		void'($urandom(31620));
		repeat (2) @(posedge clk);
		#1;
		check({pfd_tick, conv_start, conv_power, cal_busy, resync, freq_update, rsvd_mismatch}, 0, "reset");
		check(lock_window_ps, WIN_5P0_PS, "reset window");
		rst_b = 1'h1;
		gap(0, g);
		check(g, 1, "ref gap unset");
		// every precision code in both modes
		for (int i = 0; i < 8; i++)
		begin
			wr({4'h1, 18'h0, 3'($urandom), i[1:0], i[2], 4'h7});
			check(lock_window_ps, i[2] ? WIN_2P9_PS : wins[i[1:0]], "window");
		end
		// fixed words, then one reserved bit flipped
		r10 = R10_RSVD_VAL | {18'h0, conv_div($urandom_range(1300000, 600000)), 2'h3, SEL_R10};
		r12 = R12_RSVD_VAL | {16'($urandom_range(20, 3)), 12'h0, SEL_R12};
		for (int i = 0; i < 8; i++)
		begin
			w = (i % 4 == 0) ? FIXED_R8 : (i % 4 == 1) ? FIXED_R11 : (i % 4 == 2) ? r10 : r12;
			m = (i % 4 == 2) ? R10_RSVD_MASK : (i % 4 == 3) ? R12_RSVD_MASK : 32'hfffffff0;
			do
				bi = $urandom_range(31, 4);
			while (m[bi] !== 1'h1);
			if (i >= 4) w[bi] = ~w[bi];
			wr(w);
			check(rsvd_mismatch, i >= 4, "reserved flag");
			// a correct rewrite clears the flag, so each word is judged alone
			if (i >= 4)
			begin
				w[bi] = ~w[bi];
				wr(w);
				check(rsvd_mismatch, 0, "reserved flag clear");
			end
		end
		r9 = {8'h01, 10'($urandom_range(2, 1)), 5'($urandom_range(2, 1)), 5'($urandom_range(3, 1)), SEL_R9};
		wr(r9);
		w6 = {28'($urandom), 4'h6};
		wr(w6);
		u = n_upd;
		for (int i = 13; i < 16; i++)
			wr({28'($urandom) & 28'hffffffe, i[3:0]}); // mode bit clear, a stray store shows
		check(lock_window_ps, WIN_2P9_PS, "window kept");
		// power alone, then power with conversion on write
		n = n_start;
		wr(r10 & ~32'h00000020);
		check(conv_power, 1, "converter power");
		check(n_start - n, 0, "no start");
		wr(r10);
		check(n_start - n, 1, "one start");
		gap(1, g);
		check(g, r10[13:6], "converter gap");
		r4 = {5'h0, 1'($urandom), 1'($urandom), 10'(2 * $urandom_range(3, 1)), 10'h0, 1'h1, SEL_R4};
		wr(r4);
		n = n_pfd;
		repeat (20) @(posedge clk);
		#2;
		check(n_pfd - n, 0, "counters held");
		check(ref_double, r4[DBL_BIT], "doubler");
		w2 = {28'($urandom), 4'h2};
		w1 = {28'($urandom), 4'h1};
		wr(w2);
		wr(w1);
		check(n_upd - u, 0, "no update");
		check(fraction_word_applied, 0, "frac held");
		w0 = {10'($urandom), 1'h0, 1'($urandom), 16'($urandom), SEL_R0};
		wr(w0);
		check(n_upd - u, 1, "one update");
		check(int_applied, w0[19:4], "whole");
		check(fraction_word_applied, w1[27:4], "fraction");
		check(aux_fraction_applied, w2[31:18], "aux fraction");
		check(aux_modulus_applied, w2[17:4], "aux modulus");
		check(rfdiv_applied, w6[23:21], "out divider");
		r4[CRST_BIT] = 1'h0;
		wr(r4);
		gap(0, g);
		check(g, ref_div(r4), "ref gap");
		// over 16 converter cycles before register zero
		repeat (34 * r10[13:6] * ref_div(r4)) @(posedge clk);
		n = n_cal;
		wr(w0 | 32'h00200000);
		check(cal_busy, 1, "calibrating");
		s = 0;
		while (cal_busy === 1'h1 && s < 20000)
		begin
			@(posedge clk);
			s++;
		end
		#2;
		e = r9[23:14] * r9[8:4] + 176 * r9[31:24] + 55 * r9[13:9] * r9[23:14];
		check(n_cal - n >= e - 18 && n_cal - n <= e + 2, 1, "cal length");
		// half-rate lock done, target divider with autocalibration off
		r4[RCNT_LSB +: RCNT_W] = r4[RCNT_LSB +: RCNT_W] >> 1;
		wr(r4);
		wr(w2);
		wr(w1);
		gap(0, g);
		check(g, ref_div(r4), "target ref gap");
		// resync after the programmed detector ticks
		wr(w0);
		check(cal_busy, 0, "no calibration");
		check(int_applied, w0[19:4], "target whole");
		repeat (2 * ref_div(r4) * r12[31:16] + 20) @(posedge clk);
		#2;
		g = pfd_rs - pfd_upd - int'(r12[31:16]);
		check(g >= -1 && g <= 1, 1, "resync delay");
		stop_test();
	end
endmodule : tb
